// >>> design/fault_signal.sv
// Fault relay, maintenance relay, lamps, error history and manual mode control.
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
module fault_signal
  import fault_signal_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = fault_signal_pkg::TICK_CYCLES
)
(
  // Clock and reset.
  input  wire logic                                  clock_i,
  input  wire logic                                  rst_n_i,
  // Avalon-MM slave.
  input  wire logic [7:0]                            avm_address_i,
  input  wire logic                                  avm_read_i,
  input  wire logic                                  avm_write_i,
  input  wire logic [31:0]                           avm_writedata_i,
  output logic      [31:0]                           avm_readdata_o,
  output logic                                       avm_waitrequest_o,
  // Fault and maintenance sources from the instrument.
  input  wire logic [fault_signal_pkg::FAULT_N-1:0]  fault_src_i,
  input  wire logic                                  dosing_fault_i,
  input  wire logic                                  soiling_fault_i,
  input  wire logic                                  analysis_busy_i,
  // Relays, lamps and manual-mode actuators.
  output logic                                       fault_relay_o,
  output logic                                       maint_relay_o,
  output logic                                       fault_lamp_o,
  output logic                                       maint_lamp_o,
  output logic                                       fault_text_o,
  output logic                                       analysis_enable_o,
  output logic                                       flush_valve_o,
  output logic                                       loop_max_o
);
  import fault_signal_pkg::*;

  // All state of the block in one record.
  typedef struct packed {
    logic [FAULT_N-1:0]        src_m;       // First synchroniser stage of fault pins.
    logic [FAULT_N-1:0]        src_s;       // Synchronised fault pins.
    logic [2:0]                aux_m;       // First stage of busy, dosing, soiling.
    logic [2:0]                aux_s;       // Synchronised busy, dosing, soiling.
    logic [FAULT_N-1:0]        src_prev;    // Previous sample for new-fault detection.
    logic [FAULT_N-1:0]        latched;     // Faults signalled and not yet cleared.
    logic [FAULT_N-1:0]        pend;        // New faults still to be written to history.
    logic [FAULT_N-1:0]        pulse_cfg;   // One means pulsed message, zero continuous.
    logic [TICK_W-1:0]         tick_cnt;    // Divider towards the one-second tick.
    logic [2:0]                pulse_sec;   // Position in the seven-second pulse cycle.
    logic [31:0]               interval;    // Programmed maintenance interval in seconds.
    logic [31:0]               remain;      // Seconds left until maintenance is due.
    logic                      date_due;    // Maintenance date reached.
    logic [6:0]                reagent;     // Reagent filling level in percent.
    mode_e                     mode;        // Automatic or manual operation.
    logic                      flush;       // Sampling-line flushing running.
    logic                      loop_max;    // Current loop forced to maximum.
    logic [HIST_N-1:0][2:0]    hist;        // Error history, fault index per entry.
    logic [3:0]                hist_wp;     // Next history slot.
    logic [4:0]                hist_cnt;    // Entries held, saturating at the depth.
    logic                      fault_relay; // One keeps the relay in its no-fault position.
    logic                      maint_relay; // One activates the maintenance relay.
    logic                      fault_lamp;  // Red lamp and fault text.
    logic                      maint_lamp;  // Yellow lamp.
    logic                      ack;         // Bus answer strobe.
    logic [31:0]               rdata;       // Read data held for the answer.
  } state_s;

  state_s s_q;  // Registered state.
  state_s s_d;  // Next state.

  // Bus decode, valid only in the answer cycle of a write, plus the request and the one-second tick.
  logic        wr_now;   // A write takes effect at this edge.
  logic [31:0] cmd;      // Command pulses of this cycle.
  logic        horn;     // Horn acknowledge key.
  logic        confirm;  // Maintenance confirm action.
  logic        tick;     // One-second enable pulse.
  logic        req;      // Master is requesting.

  assign req     = avm_read_i | avm_write_i;
  assign wr_now  = s_q.ack & avm_write_i;
  assign cmd     = (wr_now && avm_address_i == OFS_CMD) ? avm_writedata_i : 32'h0000_0000;
  assign horn    = cmd[CMD_HORN];
  assign confirm = cmd[CMD_CONFIRM];
  assign tick    = s_q.tick_cnt == TICK_W'(TICK_CYCLES_P - 1);

  // The slave stalls the first cycle of every request so read data come from a flop.
  assign avm_waitrequest_o = req & ~s_q.ack;
  assign avm_readdata_o    = s_q.rdata;

  // Outputs straight from the state record.
  assign fault_relay_o     = s_q.fault_relay;
  assign maint_relay_o     = s_q.maint_relay;
  assign fault_lamp_o      = s_q.fault_lamp;
  assign fault_text_o      = s_q.fault_lamp;
  assign maint_lamp_o      = s_q.maint_lamp;
  assign analysis_enable_o = s_q.mode == MODE_AUTO;
  assign flush_valve_o     = s_q.flush;
  assign loop_max_o        = s_q.loop_max;

  // Next-state logic for the whole block.
  always_comb
  begin
    logic               any_cont;
    logic               any_puls;
    logic               found;
    logic [FAULT_N-1:0] rise;
    logic               maint_req;
    logic               auto_m;
    any_cont  = 1'b0;
    any_puls  = 1'b0;
    found     = 1'b0;
    rise      = '0;
    maint_req = 1'b0;
    auto_m    = s_q.mode == MODE_AUTO;
    s_d       = s_q;

    // Two-flop synchronisers; the first stage feeds only the second.
    s_d.src_m = fault_src_i;
    s_d.src_s = s_q.src_m;
    s_d.aux_m = {soiling_fault_i, dosing_fault_i, analysis_busy_i};
    s_d.aux_s = s_q.aux_m;

    // Divider producing the one-second tick.
    s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + TICK_W'(1);

    // Bus answer: one stall cycle, then waitrequest drops for one cycle.
    s_d.ack = req & ~s_q.ack;
    if (req && !s_q.ack)
    begin
      // Capture read data now so it stands at the answer edge; unmapped reads give zero.
      s_d.rdata = 32'h0000_0000;
      if (avm_address_i[7:6] == HIST_PAGE)
      begin
        s_d.rdata = {29'h0000_0000, s_q.hist[avm_address_i[5:2]]};
      end
      else
      begin
        unique case (avm_address_i)
          OFS_CFG:      s_d.rdata = {24'h00_0000, s_q.pulse_cfg};
          OFS_STATUS:   s_d.rdata = {10'h000, s_q.fault_relay, s_q.loop_max, s_q.flush,
                                     s_q.mode == MODE_MANUAL, s_q.date_due, s_q.maint_relay,
                                     s_q.latched, s_q.src_s};
          OFS_INTERVAL: s_d.rdata = s_q.interval;
          OFS_REMAIN:   s_d.rdata = s_q.remain;
          OFS_REAGENT:  s_d.rdata = {25'h000_0000, s_q.reagent};
          OFS_HISTCNT:  s_d.rdata = {27'h000_0000, s_q.hist_cnt};
          OFS_LOOP:     s_d.rdata = s_q.loop_max ? LOOP_MAX_TXT : LOOP_MIN_TXT;
          default:      s_d.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Register writes take effect at the answer edge.
    if (wr_now)
    begin
      unique case (avm_address_i)
        OFS_CFG:      s_d.pulse_cfg = avm_writedata_i[FAULT_N-1:0];
        OFS_INTERVAL: s_d.interval  = avm_writedata_i;
        OFS_REAGENT:  s_d.reagent   = avm_writedata_i[6:0];
        default:      s_d.pulse_cfg = s_q.pulse_cfg;
      endcase
    end
    if (cmd[CMD_REAGENT])
    begin
      s_d.reagent = REAGENT_FULL;
    end

    // Manual mode is entered only in an analysis pause and left on request.
    if (cmd[CMD_MAN_ON] && auto_m && !s_q.aux_s[0])
    begin
      s_d.mode = MODE_MANUAL;
    end
    else if (cmd[CMD_MAN_OFF])
    begin
      s_d.mode     = MODE_AUTO;
      s_d.flush    = 1'b0;
      s_d.loop_max = 1'b0;
    end
    // Confirm keys act only while manual functions are selected.
    if (!auto_m && cmd[CMD_FLUSH])
    begin
      s_d.flush = ~s_q.flush;
    end
    if (!auto_m && cmd[CMD_LOOP])
    begin
      s_d.loop_max = ~s_q.loop_max;
    end

    // Fault inputs are frozen in manual mode so nothing new is latched then.
    if (auto_m)
    begin
      rise         = s_q.src_s & ~s_q.src_prev;
      s_d.src_prev = s_q.src_s;
    end
    // Horn clears only faults whose cause has gone; a new fault wins over the clear.
    s_d.latched = (s_q.latched & ~({FAULT_N{horn}} & ~s_q.src_s)) | rise;
    s_d.pend    = s_q.pend | rise;

    // One history entry per cycle, lowest pending fault first; oldest overwritten when full.
    for (int i = 0; i < FAULT_N; i++)
    begin
      if (s_q.pend[i] && !found)
      begin
        found                = 1'b1;
        s_d.pend[i]          = rise[i];
        s_d.hist[s_q.hist_wp] = 3'(i);
        s_d.hist_wp          = s_q.hist_wp + 4'h1;
        if (s_q.hist_cnt != 5'(HIST_N))
        begin
          s_d.hist_cnt = s_q.hist_cnt + 5'h01;
        end
      end
    end

    // Continuous and pulsed demands; limit violations are not a source here.
    any_cont = |(s_q.latched & ~s_q.pulse_cfg);
    any_puls = |(s_q.latched & s_q.pulse_cfg);

    // Pulse cycle counter restarts whenever no pulsed-only alarm is pending.
    if (!any_puls || any_cont)
    begin
      s_d.pulse_sec = 3'h0;
    end
    else if (tick)
    begin
      s_d.pulse_sec = (s_q.pulse_sec == PULSE_ON_S + PULSE_OFF_S - 3'h1) ? 3'h0
                                                                       : s_q.pulse_sec + 3'h1;
    end

    // Maintenance timer counts seconds while an interval is programmed.
    if (confirm)
    begin
      s_d.remain   = s_q.interval;
      s_d.date_due = 1'b0;
    end
    else if (wr_now && avm_address_i == OFS_INTERVAL)
    begin
      s_d.remain = avm_writedata_i;
    end
    else if (tick && s_q.interval != 32'h0000_0000)
    begin
      if (s_q.remain <= 32'h0000_0001)
      begin
        s_d.remain   = 32'h0000_0000;
        s_d.date_due = 1'b1;
      end
      else
      begin
        s_d.remain = s_q.remain - 32'h0000_0001;
      end
    end
    maint_req = (s_q.reagent <= REAGENT_LOW) | s_q.aux_s[1] | s_q.aux_s[2]
                | s_q.date_due;

    // Relays and lamps hold their last value while manual mode is active.
    if (auto_m)
    begin
      if (any_cont)
      begin
        s_d.fault_relay = 1'b0;
      end
      else if (any_puls)
      begin
        s_d.fault_relay = s_q.pulse_sec >= PULSE_ON_S;
      end
      else
      begin
        s_d.fault_relay = 1'b1;
      end
      s_d.fault_lamp  = |s_q.latched;
      s_d.maint_relay = maint_req;
      s_d.maint_lamp  = maint_req;
    end
  end

  // State register; reset empties the history and puts relays in fail-safe positions.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_q             <= '0;
      s_q.interval    <= INTERVAL_RST;
      s_q.reagent     <= REAGENT_FULL;
      s_q.mode        <= MODE_AUTO;
      s_q.fault_relay <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // A continuous fault drives the relay to its fault position.
  property p_cont_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
    (|(s_q.latched & ~s_q.pulse_cfg)) && s_q.mode == MODE_AUTO |=> !fault_relay_o;
  endproperty
  a_cont_hold: assert property (p_cont_hold) else $error("continuous fault not held");

  // A pulsed-only alarm is on in the first two seconds of the cycle.
  property p_pulse_on;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_q.latched != '0 && (s_q.latched & ~s_q.pulse_cfg) == '0 && s_q.mode == MODE_AUTO
      && s_q.pulse_sec < PULSE_ON_S |=> !fault_relay_o;
  endproperty
  a_pulse_on: assert property (p_pulse_on) else $error("pulse on phase wrong");

  // A pulsed-only alarm is released in the remaining five seconds.
  property p_pulse_off;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_q.latched != '0 && (s_q.latched & ~s_q.pulse_cfg) == '0 && s_q.mode == MODE_AUTO
      && s_q.pulse_sec >= PULSE_ON_S |=> fault_relay_o;
  endproperty
  a_pulse_off: assert property (p_pulse_off) else $error("pulse off phase wrong");

  // With nothing latched the relay returns to its energised position.
  property p_idle_energised;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_q.latched == '0 && s_q.mode == MODE_AUTO |=> fault_relay_o && !fault_lamp_o;
  endproperty
  a_idle_energised: assert property (p_idle_energised) else $error("relay not energised");

  // An acknowledge never clears a fault whose source is still present.
  property p_ack_blocked;
    @(posedge clock_i) disable iff (!rst_n_i)
    horn && (s_q.latched & s_q.src_s) != '0 |=> s_q.latched != '0;
  endproperty
  a_ack_blocked: assert property (p_ack_blocked) else $error("active fault cleared");

  // Horn alone leaves an expired maintenance pending.
  property p_horn_no_maint;
    @(posedge clock_i) disable iff (!rst_n_i)
    horn && !confirm && s_q.date_due |=> s_q.date_due;
  endproperty
  a_horn_no_maint: assert property (p_horn_no_maint) else $error("horn cleared maintenance");

  // Confirmation reloads the interval and clears the due flag.
  property p_confirm_reload;
    @(posedge clock_i) disable iff (!rst_n_i)
    confirm |=> !s_q.date_due && s_q.remain == $past(s_q.interval);
  endproperty
  a_confirm_reload: assert property (p_confirm_reload) else $error("interval not restarted");

  // Manual mode never starts during a running analysis.
  property p_manual_pause;
    @(posedge clock_i) disable iff (!rst_n_i)
    $rose(s_q.mode) |-> !$past(s_q.aux_s[0]);
  endproperty
  a_manual_pause: assert property (p_manual_pause) else $error("manual entered in analysis");

  // A pending new fault grows the history by one entry.
  property p_hist_append;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_q.pend != '0 && s_q.hist_cnt < 5'(HIST_N) |=> s_q.hist_cnt == $past(s_q.hist_cnt) + 5'h01;
  endproperty
  a_hist_append: assert property (p_hist_append) else $error("history not appended");

  // A latched fault lights the red lamp and the fault text in automatic mode.
  property p_fault_lamp;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_q.latched != '0 && s_q.mode == MODE_AUTO |=> fault_lamp_o && fault_text_o;
  endproperty
  a_fault_lamp: assert property (p_fault_lamp) else $error("fault lamp dark");

  // Manual mode holds every relay and lamp at its last level.
  // Freezing them keeps a commissioning session from tripping the plant's alarm wiring.
  property p_manual_frozen;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_q.mode == MODE_MANUAL |=> $stable(fault_relay_o) && $stable(maint_relay_o)
      && $stable(fault_lamp_o) && $stable(maint_lamp_o);
  endproperty
  a_manual_frozen: assert property (p_manual_frozen) else $error("outputs moved in manual");

  // A reached maintenance date keeps the maintenance contact closed, never pulsed.
  property p_maint_steady;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_q.date_due && s_q.mode == MODE_AUTO |=> maint_relay_o && maint_lamp_o;
  endproperty
  a_maint_steady: assert property (p_maint_steady) else $error("maintenance not steady");

endmodule

// >>> design/fault_signal_pkg.sv
// Constants, register map and timing for the fault and maintenance signalling block.
package fault_signal_pkg;

  // Number of monitored fault sources and history depth.
  localparam int unsigned FAULT_N   = 8;
  localparam int unsigned HIST_N    = 16;

  // Clock and one-second timebase.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SECOND_NS     = 1000000000;
  localparam int unsigned TICK_CYCLES   = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W        = 27;

  // Pulsed fault message timing in seconds.
  localparam logic [2:0] PULSE_ON_S  = 3'h2;
  localparam logic [2:0] PULSE_OFF_S = 3'h5;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [7:0] OFS_CFG      = 8'h00;
  localparam logic [7:0] OFS_CMD      = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_INTERVAL = 8'h0C;
  localparam logic [7:0] OFS_REMAIN   = 8'h10;
  localparam logic [7:0] OFS_REAGENT  = 8'h14;
  localparam logic [7:0] OFS_HISTCNT  = 8'h18;
  localparam logic [7:0] OFS_LOOP     = 8'h1C;
  localparam logic [1:0] HIST_PAGE    = 2'h1;

  // Command register bit positions, each a write-one pulse.
  localparam int unsigned CMD_HORN    = 0;
  localparam int unsigned CMD_CONFIRM = 1;
  localparam int unsigned CMD_MAN_ON  = 2;
  localparam int unsigned CMD_MAN_OFF = 3;
  localparam int unsigned CMD_FLUSH   = 4;
  localparam int unsigned CMD_LOOP    = 5;
  localparam int unsigned CMD_REAGENT = 6;

  // Status register field positions: the latched fault byte and the fields above the two fault bytes.
  localparam int unsigned ST_LATCH  = 8;
  localparam int unsigned ST_MAINT  = 16;
  localparam int unsigned ST_DUE    = 17;
  localparam int unsigned ST_MANUAL = 18;
  localparam int unsigned ST_FLUSH  = 19;
  localparam int unsigned ST_LOOP   = 20;
  localparam int unsigned ST_RELAY  = 21;

  // Reset values and fixed levels.
  localparam logic [31:0] INTERVAL_RST = 32'h0000_0000;
  localparam logic [6:0]  REAGENT_FULL = 7'h64;
  localparam logic [6:0]  REAGENT_LOW  = 7'h0A;
  localparam logic [31:0] LOOP_MIN_TXT = 32'h0000_0000;
  localparam logic [31:0] LOOP_MAX_TXT = 32'h0000_00C8;

  // Operating mode of the instrument.
  typedef enum logic [0:0] {
    MODE_AUTO   = 1'b0,
    MODE_MANUAL = 1'b1
  } mode_e;

endpackage

// >>> bench/alarm_equipment.sv
// Model of the external alarm equipment that watches the fault and maintenance relay contacts.
module alarm_equipment
(
  // Clock and reset.
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Relay contacts as seen at the terminals.
  input  wire logic fault_relay_i,
  input  wire logic maint_relay_i,
  // Measured contact phases in clock cycles and maintenance pick-ups.
  output int        alarm_len_o,
  output int        quiet_len_o,
  output int        maint_rises_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int   run_q;   // Cycles since the fault contact last moved.
  logic last_q;  // Fault contact level one cycle ago.
  logic mlast_q; // Maintenance contact level one cycle ago.

  // A dropped fault relay is an alarm, so a dead device reads as a fault.
  // Each finished alarm and quiet phase is measured to time the pulses.
  // Every pick-up of the maintenance contact is counted, so a pulsing contact shows.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      run_q         <= 0;
      last_q        <= 1'b1;
      mlast_q       <= 1'b0;
      alarm_len_o   <= 0;
      quiet_len_o   <= 0;
      maint_rises_o <= 0;
    end
    else
    begin
      last_q  <= fault_relay_i;
      mlast_q <= maint_relay_i;
      run_q   <= (fault_relay_i == last_q) ? run_q + 1 : 1;
      if (fault_relay_i != last_q && !last_q)
        alarm_len_o <= run_q;
      if (fault_relay_i != last_q && last_q)
        quiet_len_o <= run_q;
      if (maint_relay_i && !mlast_q)
        maint_rises_o <= maint_rises_o + 1;
    end
  end
endmodule

// >>> bench/fault_and_maintenance_signalling_tb_top.sv
// Self-checking testbench for the fault and maintenance signalling block.
module fault_and_maintenance_signalling_tb_top;
  import fault_signal_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TK = 10; // Short one-second tick keeps the run brief.
  logic clock_i = 1'b0, rst_n_i = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [7:0]  addr = 8'h00, src = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, q;
  logic waitreq, dosing = 1'b0, soiling = 1'b0, busy = 1'b0;
  logic frelay, mrelay, flamp, mlamp, ftext, aen, flush, lmax;
  int   alen, qlen, mrise, mismatches = 0, checks = 0, cnt, m0;

  // Free-running 100 MHz clock.
  always #5 clock_i = ~clock_i;

  fault_signal #(.TICK_CYCLES_P(TK)) DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .avm_address_i(addr), .avm_read_i(rd), .avm_write_i(wr), .avm_writedata_i(wdata),
    .avm_readdata_o(rdata), .avm_waitrequest_o(waitreq), .fault_src_i(src),
    .dosing_fault_i(dosing), .soiling_fault_i(soiling), .analysis_busy_i(busy),
    .fault_relay_o(frelay), .maint_relay_o(mrelay), .fault_lamp_o(flamp),
    .maint_lamp_o(mlamp), .fault_text_o(ftext), .analysis_enable_o(aen),
    .flush_valve_o(flush), .loop_max_o(lmax));

  alarm_equipment partner (.clock_i(clock_i), .rst_n_i(rst_n_i), .fault_relay_i(frelay),
    .maint_relay_i(mrelay), .alarm_len_o(alen), .quiet_len_o(qlen), .maint_rises_o(mrise));

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Compares a seen value against the expected one.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Lets the given number of clock edges pass.
  task automatic tk(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // One Avalon transfer, held until waitrequest is seen low; the wait is bounded.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (waitreq !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (waitreq !== 1'b0)
    begin
      mismatches++;
      $display("ERROR t=%0t bus answer missing", $time);
      tally_and_finish();
    end
  endtask

  // Reads a register and compares it.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask

  // Pulses one command bit and lets its outputs settle.
  task automatic cmd(input int unsigned b);
    bus(1'b1, OFS_CMD, 32'h0000_0001 << b);
    tk(2);
  endtask

  // Reads one status bit and compares it.
  task automatic st(input int unsigned b, input logic e);
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    chk({31'h0, q[b]}, {31'h0, e});
  endtask

  // Cuts a hang short; the limit is far above the whole sequence.
  initial
  begin
    tk(20000);
    mismatches++;
    $display("ERROR t=%0t run limit reached", $time);
    tally_and_finish();
  end

  // Main sequence.
  initial
  begin
    tk(4);
    rst_n_i <= 1'b1;
    chk(frelay, 1'b1);
    chk({mrelay, flamp, aen}, 3'b001);
    rd_chk(OFS_REAGENT, 32'h0000_0064);
    rd_chk(OFS_HISTCNT, 32'h0000_0000);
    rd_chk(8'h24, 32'h0000_0000);
    // A continuous fault, acknowledged while present and then after it has gone.
    src <= 8'h01;
    tk(8);
    chk({frelay, flamp, ftext}, 3'b011);
    rd_chk(OFS_HISTCNT, 32'h0000_0001);
    rd_chk(8'h40, 32'h0000_0000);
    cmd(CMD_HORN);
    st(ST_LATCH, 1'b1);
    chk(frelay, 1'b0);
    src <= 8'h00;
    tk(6);
    cmd(CMD_HORN);
    chk({frelay, flamp}, 2'b10);
    // A pulsed fault alone, then joined by a continuous one.
    bus(1'b1, OFS_CFG, 32'h0000_0002);
    src <= 8'h02;
    tk(160);
    chk(alen, 2 * TK);
    chk(qlen, 5 * TK);
    src <= 8'h03;
    tk(8);
    cnt = 0;
    repeat (80)
    begin
      @(posedge clock_i);
      cnt += (frelay !== 1'b0);
    end
    chk(cnt, 0);
    src <= 8'h00;
    tk(6);
    cmd(CMD_HORN);
    chk(frelay, 1'b1);
    // Maintenance causes: low reagent, dosing, soiling.
    bus(1'b1, OFS_REAGENT, 32'h0000_0005);
    tk(3);
    chk({mrelay, mlamp}, 2'b11);
    bus(1'b1, OFS_REAGENT, 32'h0000_0064);
    tk(3);
    chk({mrelay, mlamp}, 2'b00);
    for (int i = 0; i < 2; i++)
    begin
      {soiling, dosing} <= 2'b01 << i;
      tk(6);
      chk(mrelay, 1'b1);
      {soiling, dosing} <= 2'b00;
      tk(6);
      chk(mlamp, 1'b0);
    end
    // Maintenance date: horn leaves it, confirmation clears it and restarts the timer.
    m0 = mrise;
    bus(1'b1, OFS_INTERVAL, 32'h0000_0003);
    tk(50);
    st(ST_DUE, 1'b1);
    cmd(CMD_HORN);
    chk({mrelay, mlamp}, 2'b11);
    chk(mrise - m0, 1);
    cmd(CMD_CONFIRM);
    chk({mrelay, mlamp}, 2'b00);
    bus(1'b0, OFS_REMAIN, 32'h0000_0000);
    chk(q == 32'h0000_0003 || q == 32'h0000_0002, 1'b1);
    bus(1'b1, OFS_INTERVAL, 32'h0000_0000);
    // Manual mode: refused while busy, then entered, frozen, and left.
    busy <= 1'b1;
    cmd(CMD_MAN_ON);
    st(ST_MANUAL, 1'b0);
    busy <= 1'b0;
    cmd(CMD_MAN_ON);
    st(ST_MANUAL, 1'b1);
    chk(aen, 1'b0);
    src <= 8'h01;
    tk(8);
    chk({frelay, flamp}, 2'b10);
    src <= 8'h00;
    cmd(CMD_FLUSH);
    chk(flush, 1'b1);
    cmd(CMD_FLUSH);
    chk(flush, 1'b0);
    cmd(CMD_LOOP);
    chk(lmax, 1'b1);
    rd_chk(OFS_LOOP, 32'h0000_00C8);
    cmd(CMD_LOOP);
    chk(lmax, 1'b0);
    rd_chk(OFS_LOOP, 32'h0000_0000);
    bus(1'b1, OFS_REAGENT, 32'h0000_0014);
    rd_chk(OFS_REAGENT, 32'h0000_0014);
    cmd(CMD_REAGENT);
    rd_chk(OFS_REAGENT, 32'h0000_0064);
    cmd(CMD_MAN_OFF);
    chk(aen, 1'b1);
    rd_chk(OFS_HISTCNT, 32'h0000_0003);
    // Power failure empties the history.
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    tk(4);
    rst_n_i <= 1'b1;
    rd_chk(OFS_HISTCNT, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
